// ===== bench/ssp_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_channel_tb_top;
	import ssp_pkg::*;
	// ********************************
	// signals
	// ********************************
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [7:0]  addr_i = 8'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [15:0] rdata_o;
	logic        dma_wr_i = 1'b0;
	logic [15:0] dma_wdata_i = 16'h0000;
	logic        dma_rd_i = 1'b0;
	logic [15:0] dma_rdata_o;
	logic        txe_irq, rxf_irq, ovr_irq, und_irq;
	logic        rxd, rxc, rxs, txc, peer_sync, dev_sync, sync_oe_n, txd, txd_oe_n;
	logic        sync_line;  // resolved sync pin
	logic [15:0] cap;
	logic [15:0] fs_pulses = 16'h0000;  // device sync pulses seen
	logic [15:0] v;
	int          mismatches = 0;
	int          checked = 0;

	// peer drives the sync pin only while the device lets go
	assign sync_line = sync_oe_n ? peer_sync : dev_sync;

	always #4 clk_i = ~clk_i;

	// count sync pulses the device drives out
	always @(posedge dev_sync)
		fs_pulses <= fs_pulses + 16'h0001;

	ssp_channel ssp_channel_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dma_wr_i(dma_wr_i), .dma_wdata_i(dma_wdata_i),
		.dma_rd_i(dma_rd_i), .dma_rdata_o(dma_rdata_o), .tx_empty_irq_o(txe_irq), .rx_full_irq_o(rxf_irq),
		.rx_overrun_irq_o(ovr_irq), .tx_underrun_irq_o(und_irq), .rx_data_in_i(rxd), .rx_bit_clock_i(rxc),
		.rx_frame_sync_i(rxs), .tx_bit_clock_i(txc), .tx_frame_sync_i(sync_line), .tx_frame_sync_o(dev_sync),
		.tx_frame_sync_oe_n_o(sync_oe_n), .tx_data_out_o(txd), .tx_data_out_oe_n_o(txd_oe_n));

	ssp_serial_peer ssp_serial_peer_inst (.tx_data_i(txd), .tx_bit_clock_o(txc), .tx_frame_sync_o(peer_sync),
		.tx_cap_o(cap), .rx_data_o(rxd), .rx_bit_clock_o(rxc), .rx_frame_sync_o(rxs));

	// ********************************
	// helpers
	// ********************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd

	task automatic dma_put(input logic [15:0] d);
		@(posedge clk_i);
		dma_wr_i    <= 1'b1;
		dma_wdata_i <= d;
		@(posedge clk_i);
		dma_wr_i <= 1'b0;
	endtask : dma_put

	// let flags and irq levels land
	task automatic settle;
		repeat (8) @(posedge clk_i);
		#1;
	endtask : settle

	// read then write zero: clears whatever read as one
	task automatic clr_status;
		logic [15:0] t;
		rd(SSP_OFS_STATUS, t);
		wr(SSP_OFS_STATUS, 16'h0000);
	endtask : clr_status

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	// ********************************
	// ordinary register cases
	// ********************************
	typedef struct packed { logic [7:0] a; logic [15:0] d; logic [15:0] e; } ssp_row_s;
	ssp_row_s rows [7] = '{
		'{SSP_OFS_TX_DATA, 16'hA5C3, 16'hA5C3},  // full sixteen bits kept
		'{SSP_OFS_CTRL,    16'hFF80, 16'h0000},  // reserved bits read zero
		'{SSP_OFS_CTRL,    16'h007C, 16'h007C},  // mode and enable fields
		'{SSP_OFS_STATUS,  16'hFFFF, 16'h0002},  // ones change nothing
		'{8'h20,           16'h1234, 16'h0000},  // unmapped
		'{SSP_OFS_RX_DATA, 16'h5555, 16'h0000},  // receive data not writable
		'{SSP_OFS_CTRL,    16'h0000, 16'h0000}};

	// watchdog, far beyond the expected run of about eight microseconds
	initial
	begin
		#200000;
		mismatches++;
		end_sim();
	end

	// ********************************
	// main sequence
	// ********************************
	initial
	begin
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, v);
			chk(v, rows[i].e);
		end
		// empty request gated, dma write clears empty
		wr(SSP_OFS_CTRL, 16'h0008);
		settle();
		chk({15'h0000, txe_irq}, 16'h0001);
		wr(SSP_OFS_TX_DATA, 16'h1111);
		dma_put(16'h00A5);
		settle();
		chk({15'h0000, txe_irq}, 16'h0000);
		rd(SSP_OFS_STATUS, v);
		chk(v, 16'h0000);
		rd(SSP_OFS_TX_DATA, v);
		chk(v, 16'h00A5);
		// enable then disable transmit
		wr(SSP_OFS_CTRL, 16'h0002);
		settle();
		chk({14'h0000, txd_oe_n, sync_oe_n}, 16'h0001);
		wr(SSP_OFS_CTRL, 16'h0000);
		settle();
		chk({15'h0000, txd_oe_n}, 16'h0001);
		rd(SSP_OFS_STATUS, v);
		chk(v, 16'h0002);
		wr(SSP_OFS_STATUS, 16'h0000);
		rd(SSP_OFS_STATUS, v);
		chk(v, 16'h0000);
		// continuous 8-bit send, internal sync; the reload underruns
		dma_put(16'h00A5);
		wr(SSP_OFS_CTRL, 16'h0042);
		settle();
		chk({15'h0000, sync_oe_n}, 16'h0000);
		ssp_serial_peer_inst.tx_run(9, 1'b0);
		settle();
		chk(cap, 16'h00A5);
		chk(fs_pulses, 16'h0001);
		rd(SSP_OFS_STATUS, v);
		chk(v, 16'h000A);
		chk({15'h0000, und_irq}, 16'h0001);
		clr_status();
		rd(SSP_OFS_STATUS, v);
		chk(v, 16'h0000);
		wr(SSP_OFS_CTRL, 16'h0000);
		// interval 16-bit send on an external sync
		dma_put(16'hC35A);
		wr(SSP_OFS_CTRL, 16'h0032);
		ssp_serial_peer_inst.tx_run(17, 1'b1);
		settle();
		chk(cap, 16'hC35A);
		rd(SSP_OFS_STATUS, v);
		chk(v, 16'h0002);
		chk(fs_pulses, 16'h0001);
		wr(SSP_OFS_CTRL, 16'h0000);
		// 16-bit receive, then a second word while full
		wr(SSP_OFS_CTRL, 16'h0035);
		ssp_serial_peer_inst.rx_word(16'hC3A5, 16, 1'b1);
		settle();
		chk(dma_rdata_o, 16'hC3A5);
		chk({15'h0000, rxf_irq}, 16'h0001);
		rd(SSP_OFS_RX_DATA, v);
		chk(v, 16'hC3A5);
		ssp_serial_peer_inst.rx_word(16'h1234, 16, 1'b1);
		settle();
		chk(dma_rdata_o, 16'h1234);
		chk({15'h0000, ovr_irq}, 16'h0001);
		@(posedge clk_i);
		dma_rd_i <= 1'b1;
		@(posedge clk_i);
		dma_rd_i <= 1'b0;
		settle();
		rd(SSP_OFS_STATUS, v);
		chk(v & 16'h0005, 16'h0004);
		clr_status();
		rd(SSP_OFS_STATUS, v);
		chk(v & 16'h0005, 16'h0000);
		// mode change with receive off, then continuous 8-bit words
		wr(SSP_OFS_CTRL, 16'h0000);
		wr(SSP_OFS_CTRL, 16'h0005);
		ssp_serial_peer_inst.rx_word(16'h005A, 8, 1'b1);
		settle();
		chk(dma_rdata_o, 16'h005A);
		chk({15'h0000, rxf_irq}, 16'h0001);
		ssp_serial_peer_inst.rx_word(16'h00C3, 8, 1'b0);
		settle();
		chk(dma_rdata_o, 16'h00C3);
		wr(SSP_OFS_CTRL, 16'h0000);
		settle();
		rd(SSP_OFS_STATUS, v);
		chk(v & 16'h0001, 16'h0000);
		// receive off: a word on the pins is ignored
		ssp_serial_peer_inst.rx_word(16'h00FF, 8, 1'b1);
		settle();
		chk(dma_rdata_o, 16'h00C3);
		rd(SSP_OFS_STATUS, v);
		chk(v & 16'h0001, 16'h0000);
		// second reset in mid-run
		wr(SSP_OFS_TX_DATA, 16'hFFFF);
		wr(SSP_OFS_CTRL, 16'h000C);
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(SSP_OFS_STATUS, v);
		chk(v, 16'h0002);
		rd(SSP_OFS_CTRL, v);
		chk(v, 16'h0000);
		rd(SSP_OFS_TX_DATA, v);
		chk(v, 16'h0000);
		chk({12'h000, txe_irq, rxf_irq, ovr_irq, und_irq}, 16'h0000);
		end_sim();
	end
endmodule : ssp_channel_tb_top
`default_nettype wire

// ===== bench/ssp_serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// far-side serial device model
// ********************************
module ssp_serial_peer
(
	// transmit side
	input  wire logic       tx_data_i,
	output logic            tx_bit_clock_o,
	output logic            tx_frame_sync_o,
	output logic [15:0]     tx_cap_o,
	// receive side
	output logic            rx_data_o,
	output logic            rx_bit_clock_o,
	output logic            rx_frame_sync_o
);
	int unsigned rise_cnt;  // rising edges in this burst

	// clocks stand still low outside frames
	initial
	begin
		tx_bit_clock_o  = 1'b0;
		tx_frame_sync_o = 1'b0;
		tx_cap_o        = 16'h0000;
		rx_data_o       = 1'b0;
		rx_bit_clock_o  = 1'b0;
		rx_frame_sync_o = 1'b0;
	end

	// burst of n transmit clocks, 80 ns each; fs raises sync for the first bit only
	// capture from the second rise on, so the device's synchroniser delay is covered
	task automatic tx_run(input int n, input logic fs);
		rise_cnt        = 0;
		tx_cap_o        = 16'h0000;
		tx_frame_sync_o = fs;
		repeat (n)
		begin
			#40 tx_bit_clock_o = 1'b1;
			rise_cnt++;
			if (rise_cnt >= 2)
				tx_cap_o = {tx_cap_o[14:0], tx_data_i};
			#40 tx_bit_clock_o = 1'b0;
			tx_frame_sync_o = 1'b0;
		end
	endtask : tx_run

	// one word msb first, sync with the first bit only
	// data moves mid low phase, well away from the sampling fall
	task automatic rx_word(input logic [15:0] w, input int n, input logic s);
		for (int i = n - 1; i >= 0; i--)
		begin
			rx_data_o       = w[i];
			rx_frame_sync_o = s && (i == n - 1);
			#20 rx_bit_clock_o = 1'b1;
			#40 rx_bit_clock_o = 1'b0;
			#20;
		end
		rx_frame_sync_o = 1'b0;
		// released line: not left at the last value
		rx_data_o = ~rx_data_o;
	endtask : rx_word
endmodule : ssp_serial_peer
`default_nettype wire

// ===== logic/ssp_channel.sv
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ssp_channel
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	// dma engine port
	input  wire logic        dma_wr_i,
	input  wire logic [15:0] dma_wdata_i,
	input  wire logic        dma_rd_i,
	output logic      [15:0] dma_rdata_o,
	// interrupt requests
	output logic             tx_empty_irq_o,
	output logic             rx_full_irq_o,
	output logic             rx_overrun_irq_o,
	output logic             tx_underrun_irq_o,
	// serial receive pins
	input  wire logic        rx_data_in_i,
	input  wire logic        rx_bit_clock_i,
	input  wire logic        rx_frame_sync_i,
	// serial transmit pins
	input  wire logic        tx_bit_clock_i,
	input  wire logic        tx_frame_sync_i,
	output logic             tx_frame_sync_o,
	output logic             tx_frame_sync_oe_n_o,
	output logic             tx_data_out_o,
	output logic             tx_data_out_oe_n_o
);
	import ssp_pkg::*;

	// ********************************
	// pin synchronisers
	// ********************************
	// bit order: 0 rx data, 1 rx clock, 2 rx sync, 3 tx clock, 4 tx sync
	logic [4:0] pin_raw;    // raw pin levels
	logic [4:0] s1_r;       // first stage, read by s2 only
	logic [4:0] s2_r;       // second stage
	logic [4:0] s3_r;       // third stage
	logic [4:0] filt_r;     // accepted level
	logic [4:0] filt_d_r;   // accepted level, one cycle old

	assign pin_raw = {tx_frame_sync_i, tx_bit_clock_i, rx_frame_sync_i, rx_bit_clock_i, rx_data_in_i};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_sync
			// a change is taken only when stages two and three agree
			always_ff @(posedge clk_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					s1_r[gi]     <= 1'b0;
					s2_r[gi]     <= 1'b0;
					s3_r[gi]     <= 1'b0;
					filt_r[gi]   <= 1'b0;
					filt_d_r[gi] <= 1'b0;
				end
				else
				begin
					s1_r[gi]     <= pin_raw[gi];
					s2_r[gi]     <= s1_r[gi];
					s3_r[gi]     <= s2_r[gi];
					filt_r[gi]   <= (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
					filt_d_r[gi] <= filt_r[gi];
				end
			end
		end
	endgenerate

	wire rx_bit  = filt_r[0];                      // sampled receive data
	wire rx_fall = filt_d_r[1] & ~filt_r[1];       // receive clock falling
	wire rx_fs   = filt_r[2];                      // receive sync level
	wire tx_rise = filt_r[3] & ~filt_d_r[3];       // transmit clock rising
	wire tx_fs   = filt_r[4];                      // external transmit sync

	// ********************************
	// registers
	// ********************************
	logic [15:0] tx_data_buf_r;   // next transmit word
	logic [15:0] tx_shift_buf_r;  // word being sent
	logic [15:0] rx_data_buf_r;   // last received word
	logic [15:0] rx_shift_buf_r;  // word being received
	logic [6:0]  ctrl_r;          // control word bits
	logic [3:0]  stat_r;          // status flags
	logic [3:0]  seen_r;          // flags read as one since last status write
	logic [15:0] rdata_r;         // read answer
	logic [4:0]  rx_cnt_r;        // received bits in word
	logic        rx_busy_r;       // receive word in progress
	logic [4:0]  tx_cnt_r;        // sent bits in word
	logic        tx_busy_r;       // transmit word in progress
	logic        tx_out_r;        // transmit data pin level
	logic        tx_fs_out_r;     // internal sync level
	logic        tx_oe_n_r;       // transmit data enable, low drives
	logic        fs_oe_n_r;       // sync pin enable, low drives
	logic [3:0]  irq_r;           // request outputs

	// ********************************
	// decode
	// ********************************
	wire sel_tx   = (addr_i == SSP_OFS_TX_DATA);
	wire sel_ctl  = (addr_i == SSP_OFS_CTRL);
	wire sel_st   = (addr_i == SSP_OFS_STATUS);
	wire sel_rx   = (addr_i == SSP_OFS_RX_DATA);
	wire wr_tx    = wr_i & sel_tx;
	wire wr_ctl   = wr_i & sel_ctl;
	wire wr_st    = wr_i & sel_st;
	wire rd_st    = rd_i & sel_st;

	// control fields
	wire c_re  = ctrl_r[SSP_CTL_RE];
	wire c_te  = ctrl_r[SSP_CTL_TE];
	wire c_rie = ctrl_r[SSP_CTL_RIE];
	wire c_tie = ctrl_r[SSP_CTL_TIE];
	wire c_dl  = ctrl_r[SSP_CTL_DL];
	wire c_se  = ctrl_r[SSP_CTL_SE];
	wire c_tm  = ctrl_r[SSP_CTL_TM];

	// reserved bits are dropped on write
	wire [6:0] ctrl_nxt = wr_ctl ? wdata_i[6:0] : ctrl_r;
	wire te_fall = c_te & ~ctrl_nxt[SSP_CTL_TE];
	wire re_fall = c_re & ~ctrl_nxt[SSP_CTL_RE];

	// word length in bits
	wire [4:0] word_len = c_dl ? SSP_LEN16 : SSP_LEN8;

	// ********************************
	// receive path
	// ********************************
	// a word begins on a sync only when idle; continuous mode keeps going
	wire        rx_go        = rx_fall & c_re & (rx_busy_r | rx_fs);
	wire        rx_done      = rx_go & (rx_cnt_r == word_len - 5'h01);
	wire [15:0] rx_shift_nxt = {rx_shift_buf_r[14:0], rx_bit};
	wire [15:0] rx_word      = c_dl ? rx_shift_nxt : {8'h00, rx_shift_nxt[7:0]};

	// receive shifter, sampled on falling receive clock
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rx_shift_buf_r <= SSP_DATA_RST;
			rx_cnt_r       <= 5'h00;
			rx_busy_r      <= 1'b0;
		end
		else if (!ctrl_nxt[SSP_CTL_RE])
		begin
			// disabled or being disabled: pins ignored, word dropped
			rx_cnt_r  <= 5'h00;
			rx_busy_r <= 1'b0;
		end
		else if (rx_go)
		begin
			rx_shift_buf_r <= rx_shift_nxt;
			rx_cnt_r       <= rx_done ? 5'h00 : rx_cnt_r + 5'h01;
			rx_busy_r      <= rx_done ? ~c_se : 1'b1;
		end
	end

	// receive buffer; an overrun still overwrites the old word
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rx_data_buf_r <= SSP_DATA_RST;
		else if (rx_done)
			rx_data_buf_r <= rx_word;
	end

	// ********************************
	// transmit path
	// ********************************
	wire tx_last  = tx_busy_r & (tx_cnt_r == word_len - 5'h01);
	// start needs a sync when idle or at the end of an interval word
	wire tx_start = tx_rise & c_te & (~tx_busy_r | (tx_last & c_se)) & (c_tm | tx_fs);
	// continuous mode reloads at the end of each word without a sync
	wire tx_cont  = tx_rise & c_te & tx_last & ~c_se;
	wire tx_load  = tx_start | tx_cont;

	// shifted word and the bit that goes out next
	wire [15:0] tx_shl     = {tx_shift_buf_r[14:0], 1'b0};
	wire        tx_msb_buf = c_dl ? tx_data_buf_r[15] : tx_data_buf_r[7];
	wire        tx_msb_shl = c_dl ? tx_shl[15] : tx_shl[7];

	// transmit shifter, stepped on rising transmit clock
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tx_shift_buf_r <= SSP_DATA_RST;
			tx_cnt_r       <= 5'h00;
			tx_busy_r      <= 1'b0;
			tx_out_r       <= 1'b0;
		end
		else if (!c_te)
		begin
			// disabled: shifter idles
			tx_cnt_r  <= 5'h00;
			tx_busy_r <= 1'b0;
			tx_out_r  <= 1'b0;
		end
		else if (tx_load)
		begin
			tx_shift_buf_r <= tx_data_buf_r;
			tx_cnt_r       <= 5'h00;
			tx_busy_r      <= 1'b1;
			tx_out_r       <= tx_msb_buf;
		end
		else if (tx_rise && tx_busy_r)
		begin
			tx_shift_buf_r <= tx_shl;
			tx_cnt_r       <= tx_cnt_r + 5'h01;
			tx_busy_r      <= ~tx_last;
			tx_out_r       <= tx_last ? 1'b0 : tx_msb_shl;
		end
	end

	// internal sync: high for the first bit of a synced word
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			tx_fs_out_r <= 1'b0;
		else if (!c_te)
			tx_fs_out_r <= 1'b0;
		else if (tx_rise)
			tx_fs_out_r <= tx_start & c_tm;
	end

	// pin enables track the control word, low means driven
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tx_oe_n_r <= 1'b1;
			fs_oe_n_r <= 1'b1;
		end
		else
		begin
			tx_oe_n_r <= ~ctrl_nxt[SSP_CTL_TE];
			fs_oe_n_r <= ~(ctrl_nxt[SSP_CTL_TE] & ctrl_nxt[SSP_CTL_TM]);
		end
	end

	// transmit buffer; cpu write wins over a dma write in the same cycle
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			tx_data_buf_r <= SSP_DATA_RST;
		else if (wr_tx)
			tx_data_buf_r <= wdata_i;
		else if (dma_wr_i)
			tx_data_buf_r <= dma_wdata_i;
	end

	// control word; mode bits are not guarded, software disables first
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ctrl_r <= SSP_CTRL_RST;
		else
			ctrl_r <= ctrl_nxt;
	end

	// ********************************
	// status flags
	// ********************************
	// a zero write clears only a flag seen as one; ones are ignored
	wire [3:0] sw_clr = {4{wr_st}} & ~wdata_i[3:0] & seen_r;

	// hardware set conditions, each wins over any clear
	wire set_und = tx_load & stat_r[SSP_ST_TXE];
	wire set_ovr = rx_done & stat_r[SSP_ST_RXF];
	wire set_txe = tx_load | te_fall;
	wire set_rxf = rx_done;

	// clear conditions
	wire clr_txe = sw_clr[SSP_ST_TXE] | dma_wr_i;
	wire clr_rxf = sw_clr[SSP_ST_RXF] | dma_rd_i | re_fall;

	wire [3:0] stat_nxt;
	assign stat_nxt[SSP_ST_UND] = set_und | (stat_r[SSP_ST_UND] & ~sw_clr[SSP_ST_UND]);
	assign stat_nxt[SSP_ST_OVR] = set_ovr | (stat_r[SSP_ST_OVR] & ~sw_clr[SSP_ST_OVR]);
	assign stat_nxt[SSP_ST_TXE] = set_txe | (stat_r[SSP_ST_TXE] & ~clr_txe);
	assign stat_nxt[SSP_ST_RXF] = set_rxf | (stat_r[SSP_ST_RXF] & ~clr_rxf);

	// flag register, reset leaves only tx empty set
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			stat_r <= SSP_STAT_RST;
		else
			stat_r <= stat_nxt;
	end

	// read-one tracking; any status write consumes it
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			seen_r <= 4'h0;
		else if (wr_st)
			seen_r <= 4'h0;
		else if (rd_st)
			seen_r <= seen_r | stat_r;
	end

	// ********************************
	// interrupt requests
	// ********************************
	// taken from next values so the pin matches the flag in the same cycle
	wire [3:0] irq_nxt = {stat_nxt[SSP_ST_UND],
	                      stat_nxt[SSP_ST_OVR],
	                      stat_nxt[SSP_ST_TXE] & ctrl_nxt[SSP_CTL_TIE],
	                      stat_nxt[SSP_ST_RXF] & ctrl_nxt[SSP_CTL_RIE]};

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			irq_r <= 4'h0;
		else
			irq_r <= irq_nxt;
	end

	// ********************************
	// read port
	// ********************************
	// unmapped offsets answer zero; reserved bits read zero
	wire [15:0] rd_mux = sel_rx  ? rx_data_buf_r :
	                     sel_tx  ? tx_data_buf_r :
	                     sel_ctl ? {9'h000, ctrl_r} :
	                     sel_st  ? {12'h000, stat_r} :
	                               16'h0000;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_r <= 16'h0000;
		else
			rdata_r <= rd_i ? rd_mux : 16'h0000;
	end

	// ********************************
	// outputs
	// ********************************
	assign rdata_o              = rdata_r;
	assign dma_rdata_o          = rx_data_buf_r;
	assign tx_underrun_irq_o    = irq_r[3];
	assign rx_overrun_irq_o     = irq_r[2];
	assign tx_empty_irq_o       = irq_r[1];
	assign rx_full_irq_o        = irq_r[0];
	assign tx_frame_sync_o      = tx_fs_out_r;
	assign tx_frame_sync_oe_n_o = fs_oe_n_r;
	assign tx_data_out_o        = tx_out_r;
	assign tx_data_out_oe_n_o   = tx_oe_n_r;

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_ctl_read;
		rd_i && sel_ctl;
	endsequence

	sequence s_dma_fill;
		dma_wr_i && !wr_tx && !tx_load && !te_fall;
	endsequence

	tx_buf_write_a: assert property (wr_tx |=> tx_data_buf_r == $past(wdata_i))
		else $error("transmit buffer not replaced by write");
	tx_irq_level_a: assert property (tx_empty_irq_o == (stat_r[SSP_ST_TXE] && c_tie))
		else $error("tx empty request does not match flag and enable");
	dma_clr_empty_a: assert property (s_dma_fill |=> !stat_r[SSP_ST_TXE] && tx_data_buf_r == $past(dma_wdata_i))
		else $error("dma write did not clear tx empty");
	no_sw_set_a: assert property (wr_st && !stat_r[SSP_ST_TXE] && !set_txe |=> !stat_r[SSP_ST_TXE])
		else $error("software set tx empty");
	te_off_empty_a: assert property (te_fall |=> stat_r[SSP_ST_TXE] ##1 tx_data_out_oe_n_o)
		else $error("tx disable did not set empty");
	ctl_read_a: assert property (s_ctl_read |=> rdata_o == {9'h000, $past(ctrl_r)})
		else $error("control read answer wrong");
	tx_float_a: assert property (!c_te |-> tx_data_out_oe_n_o && tx_frame_sync_oe_n_o)
		else $error("transmit pins driven while disabled");
	underrun_set_a: assert property (set_und |=> stat_r[SSP_ST_UND] ##1 tx_underrun_irq_o)
		else $error("underrun not flagged");
	overrun_set_a: assert property (rx_done && stat_r[SSP_ST_RXF] |=> stat_r[SSP_ST_OVR] && stat_r[SSP_ST_RXF])
		else $error("overrun not flagged");
	rx_full_set_a: assert property (rx_done |=> stat_r[SSP_ST_RXF] && rx_data_buf_r == $past(rx_word))
		else $error("received word not stored");
	rx_off_clear_a: assert property (re_fall && !rx_done |=> !stat_r[SSP_ST_RXF] && !rx_busy_r)
		else $error("rx disable did not clear full");

endmodule : ssp_channel
`default_nettype wire

// ===== logic/ssp_pkg.sv
package ssp_pkg;

	// ********************************
	// register offsets
	// ********************************
	localparam logic [7:0] SSP_OFS_RX_DATA = 8'h10;  // receive data, read only
	localparam logic [7:0] SSP_OFS_TX_DATA = 8'h12;  // transmit data buffer
	localparam logic [7:0] SSP_OFS_CTRL    = 8'h14;  // control word
	localparam logic [7:0] SSP_OFS_STATUS  = 8'h16;  // status word

	// ********************************
	// control field positions
	// ********************************
	localparam int SSP_CTL_RE  = 0;  // rx enable
	localparam int SSP_CTL_TE  = 1;  // tx enable
	localparam int SSP_CTL_RIE = 2;  // rx full irq enable
	localparam int SSP_CTL_TIE = 3;  // tx empty irq enable
	localparam int SSP_CTL_DL  = 4;  // word length pick
	localparam int SSP_CTL_SE  = 5;  // sync every word
	localparam int SSP_CTL_TM  = 6;  // tx sync source

	// ********************************
	// status field positions
	// ********************************
	localparam int SSP_ST_RXF = 0;  // rx full
	localparam int SSP_ST_TXE = 1;  // tx empty
	localparam int SSP_ST_OVR = 2;  // rx overrun
	localparam int SSP_ST_UND = 3;  // tx underrun

	// ********************************
	// reset values and counts
	// ********************************
	localparam logic [15:0] SSP_DATA_RST = 16'h0000;  // data buffers
	localparam logic [6:0]  SSP_CTRL_RST = 7'h00;     // control word
	localparam logic [3:0]  SSP_STAT_RST = 4'h2;      // only tx empty set
	localparam logic [4:0]  SSP_LEN8     = 5'h08;     // short word bits
	localparam logic [4:0]  SSP_LEN16    = 5'h10;     // long word bits

endpackage : ssp_pkg
